//--- hw/tmr_top.sv
// timer run control with masked writes, and the timer zero counter
// assumes synchronous inputs; timers one to three live elsewhere
//
// Functional notes
// - masked write updates only selected run bits
// - FFh sets all, F0h changes none
// - run bits show and start/stop timers
// - low four bits are write-only masks
// - halt timer zero after first receive nibble
// - halt setting ignored in trimming modes
// - mode 00 no autostart, 01 at tx end
// - trimming modes: rising edges start and stop
// - auto-restart reloads at zero, else stops; mode 10 always stops
// - underflow sets the interrupt request flag
// - tick select: fast, slow, timer2, timer1
// - start loads counter from reload bytes
// - reload writes apply at next start or auto-restart only
// - reload low byte at index 11h
module tmr_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link events
  input  wire logic        tx_end_i,
  input  wire logic        rx_first_nibble_i,
  input  wire logic        low_freq_oscillator_i,
  input  wire logic        timer_one_uflow_i,
  input  wire logic        timer_two_uflow_i,
  // timer state
  output logic [3:0]       timer_active_o,
  output logic             timer_zero_uflow_o,
  output logic             irq_o
);

  // ==================================================================
  // registers
  logic [3:0]          run_q;
  logic [3:0]          run_d;
  tmr_pkg::tmr_t0ctl_s ctl_q;
  logic [7:0]          rld_hi_q;
  logic [7:0]          rld_lo_q;
  logic [15:0]         cnt_q;
  logic [15:0]         cnt_d;
  logic [5:0]          div_q;
  logic                lfo_q;
  logic [1:0]          sts_q;
  logic [1:0]          sts_d;
  logic [1:0]          msk_q;
  logic                uflow_q;
  logic                irq_q;
  logic                awready_q;
  logic                arready_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;

  // ==================================================================
  // bus decode
  wire       wr_fire   = s_axi_awvalid & s_axi_wvalid & awready_q;
  wire [5:0] wr_idx    = s_axi_awaddr[7:2];
  wire       wr_en     = wr_fire & s_axi_wstrb[0];
  wire [7:0] wd        = s_axi_wdata[7:0];
  wire       sel_run   = wr_en & (wr_idx == tmr_pkg::IDX_RUN_CTRL);
  wire       sel_ctl   = wr_en & (wr_idx == tmr_pkg::IDX_T0_CTRL);
  wire       sel_hi    = wr_en & (wr_idx == tmr_pkg::IDX_T0_RLD_HI);
  wire       sel_lo    = wr_en & (wr_idx == tmr_pkg::IDX_T0_RLD_LO);
  wire       sel_sts   = wr_en & (wr_idx == tmr_pkg::IDX_IRQ_STAT);
  wire       sel_msk   = wr_en & (wr_idx == tmr_pkg::IDX_IRQ_MASK);
  wire       wr_map    = (wr_idx == tmr_pkg::IDX_RUN_CTRL)
                       | (wr_idx == tmr_pkg::IDX_T0_CTRL)
                       | (wr_idx == tmr_pkg::IDX_T0_RLD_HI)
                       | (wr_idx == tmr_pkg::IDX_T0_RLD_LO)
                       | (wr_idx == tmr_pkg::IDX_IRQ_STAT)
                       | (wr_idx == tmr_pkg::IDX_IRQ_MASK);
  wire       rd_fire   = s_axi_arvalid & arready_q;
  wire [5:0] rd_idx    = s_axi_araddr[7:2];
  wire       ctl_rd_hit = rd_idx == tmr_pkg::IDX_T0_CTRL;

  // ==================================================================
  // timer zero events
  wire [15:0] reload_w  = {rld_hi_q, rld_lo_q};
  wire        div_hit   = div_q == tmr_pkg::SLOW_DIV_MAX;
  wire        lfo_mode  = ctl_q.start_mode[1];
  wire        tick_w    =
    (ctl_q.tick_select == tmr_pkg::TICK_SYS)   ? 1'b1 :
    (ctl_q.tick_select == tmr_pkg::TICK_SLOW)  ? div_hit :
    (ctl_q.tick_select == tmr_pkg::TICK_T2_UF) ? timer_two_uflow_i :
                                                 timer_one_uflow_i;
  wire        at_zero   = run_q[0] & tick_w & (cnt_q == 16'h0000);
  // trimming without underflow just parks at zero, no flag
  wire        no_uf     = ctl_q.start_mode == tmr_pkg::START_LFO_NUF;
  wire        uflow_w   = at_zero & ~no_uf;
  // rising oscillator edge toggles the run state
  wire        lfo_rise  = lfo_mode & low_freq_oscillator_i & ~lfo_q;
  // receive halt, masked in trimming modes
  wire        rx_stop   = rx_first_nibble_i & ctl_q.halt_on_rx
                        & ~lfo_mode & run_q[0];
  wire        tx_start  = tx_end_i & ~run_q[0]
                        & (ctl_q.start_mode == tmr_pkg::START_TX_END);
  wire        hw_start  = tx_start | (lfo_rise & ~run_q[0]);
  wire        hw_stop   = rx_stop | (lfo_rise & run_q[0])
                        | (at_zero & (~ctl_q.reload_on_zero | no_uf));
  wire        sw_m0     = sel_run & wd[tmr_pkg::RUN_MASK_LSB];
  wire        sw_v0     = wd[tmr_pkg::RUN_ACT_LSB];
  // software write to the run bit wins over link events
  wire        run0_w    = sw_m0 ? sw_v0 : (hw_start | (run_q[0] & ~hw_stop));
  wire        start0    = sw_m0 ? (sw_v0 & ~run_q[0]) : hw_start;
  wire        restart0  = uflow_w & ctl_q.reload_on_zero & run0_w;

  // masked update of the run bits
  assign run_d = {sel_run ? ((wd[7:5] & wd[3:1]) | (run_q[3:1] & ~wd[3:1]))
                          : run_q[3:1], run0_w};

  // counter loads only at a start or restart
  assign cnt_d = (start0 | restart0) ? reload_w :
                 (run_q[0] & tick_w & (cnt_q != 16'h0000)) ?
                 16'(cnt_q - 16'h0001) : cnt_q;

  // sticky flags, a set wins over a clear
  assign sts_d = ({rx_stop, uflow_w})
               | (sts_q & ~(sel_sts ? wd[1:0] : 2'h0));

  // ==================================================================
  // read mux; mask bits and reserved bits read as zero
  wire [31:0] rd_w =
    (rd_idx == tmr_pkg::IDX_RUN_CTRL)  ? {24'h0, run_q, 4'h0} :
    ctl_rd_hit ? {24'h0, ctl_q.halt_on_rx, 1'b0, ctl_q.start_mode,
                  ctl_q.reload_on_zero, 1'b0, ctl_q.tick_select} :
    (rd_idx == tmr_pkg::IDX_T0_RLD_HI) ? {24'h0, rld_hi_q} :
    (rd_idx == tmr_pkg::IDX_T0_RLD_LO) ? {24'h0, rld_lo_q} :
    (rd_idx == tmr_pkg::IDX_IRQ_STAT)  ? {30'h0, sts_q} :
    (rd_idx == tmr_pkg::IDX_IRQ_MASK)  ? {30'h0, msk_q} :
    (rd_idx == tmr_pkg::IDX_T0_COUNT)  ? {16'h0, cnt_q} : 32'h0;
  wire rd_map = (rd_idx == tmr_pkg::IDX_RUN_CTRL) | ctl_rd_hit
              | (rd_idx == tmr_pkg::IDX_T0_RLD_HI)
              | (rd_idx == tmr_pkg::IDX_T0_RLD_LO)
              | (rd_idx == tmr_pkg::IDX_IRQ_STAT)
              | (rd_idx == tmr_pkg::IDX_IRQ_MASK)
              | (rd_idx == tmr_pkg::IDX_T0_COUNT);

  // ==================================================================
  // axi4-lite slave: address and data are taken together
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= tmr_pkg::RESP_OKAY;
    end else begin
      awready_q <= s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= tmr_pkg::RESP_OKAY;
    end else begin
      arready_q <= s_axi_arvalid & ~arready_q & ~rvalid_q;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_w;
        rresp_q  <= rd_map ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ==================================================================
  // configuration registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctl_q    <= tmr_pkg::tmr_t0ctl_s'(tmr_pkg::CTRL_RST);
      rld_hi_q <= tmr_pkg::RELOAD_RST;
      rld_lo_q <= tmr_pkg::RELOAD_RST;
      msk_q    <= tmr_pkg::IRQ_RST;
    end else begin
      if (sel_ctl) ctl_q <= tmr_pkg::tmr_t0ctl_s'(wd & 8'hBB);
      if (sel_hi) rld_hi_q <= wd;
      if (sel_lo) rld_lo_q <= wd;
      if (sel_msk) msk_q <= wd[1:0];
    end
  end

  // ==================================================================
  // timer state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      run_q   <= tmr_pkg::RUN_RST;
      cnt_q   <= 16'h0000;
      div_q   <= 6'h00;
      lfo_q   <= 1'b0;
      sts_q   <= tmr_pkg::IRQ_RST;
      uflow_q <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      // run bits start and stop at once
      run_q   <= run_d;
      cnt_q   <= cnt_d;
      div_q   <= div_hit ? 6'h00 : 6'(div_q + 6'h01);
      lfo_q   <= low_freq_oscillator_i;
      sts_q   <= sts_d;
      uflow_q <= uflow_w;
      // one cycle behind the flags so the pin stays a flop
      irq_q   <= |(sts_q & msk_q);
    end
  end

  assign s_axi_awready      = awready_q;
  assign s_axi_wready       = awready_q;
  assign s_axi_bvalid       = bvalid_q;
  assign s_axi_bresp        = bresp_q;
  assign s_axi_arready      = arready_q;
  assign s_axi_rvalid       = rvalid_q;
  assign s_axi_rdata        = rdata_q;
  assign s_axi_rresp        = rresp_q;
  assign timer_active_o     = run_q;
  assign timer_zero_uflow_o = uflow_q;
  assign irq_o              = irq_q;

  // ==================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_mask_write;
    sel_run |=> run_q[3:1] == (($past(wd[7:5]) & $past(wd[3:1]))
                              | ($past(run_q[3:1]) & ~$past(wd[3:1])));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("masked run write wrong");

  property p_all_set;
    (sel_run && wd == 8'hFF) |=> run_q == 4'hF;
  endproperty
  a_all_set: assert property (p_all_set)
    else $error("FFh did not set all run bits");

  property p_none_changed;
    (sel_run && wd == 8'hF0) |=> run_q[3:1] == $past(run_q[3:1]);
  endproperty
  a_none_changed: assert property (p_none_changed)
    else $error("F0h changed run bits");

  property p_sw_start;
    (sw_m0 && sw_v0 && !run_q[0]) |=> run_q[0] && cnt_q == $past(reload_w);
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("software start did not load counter");

  property p_rx_halt;
    (rx_first_nibble_i && ctl_q.halt_on_rx && !lfo_mode && run_q[0]
      && !sw_m0) |=> !run_q[0];
  endproperty
  a_rx_halt: assert property (p_rx_halt)
    else $error("receive halt missed");

  property p_rx_ignored;
    (rx_first_nibble_i && lfo_mode && run_q[0] && !sw_m0 && !lfo_rise
      && !at_zero) |=> run_q[0];
  endproperty
  a_rx_ignored: assert property (p_rx_ignored)
    else $error("halt acted in trimming mode");

  property p_tx_start;
    (tx_end_i && ctl_q.start_mode == tmr_pkg::START_TX_END && !run_q[0]
      && !sw_m0) |=> run_q[0] && cnt_q == $past(reload_w);
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("tx end did not start timer zero");

  property p_restart;
    (uflow_w && ctl_q.reload_on_zero && !sw_m0 && !rx_stop && !lfo_rise)
      |=> run_q[0] && cnt_q == $past(reload_w);
  endproperty
  a_restart: assert property (p_restart)
    else $error("auto-restart failed");

  property p_uflow_flag;
    uflow_w |=> sts_q[tmr_pkg::IRQ_UFLOW]
      ##1 (irq_o == $past(msk_q[0]) || $past(sts_q[1]));
  endproperty
  a_uflow_flag: assert property (p_uflow_flag)
    else $error("underflow flag not set");

  property p_decrement;
    (run_q[0] && tick_w && cnt_q != 16'h0000 && !start0)
      |=> cnt_q == 16'($past(cnt_q) - 16'h0001);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter did not decrement");

  property p_slow_tick;
    (ctl_q.tick_select == tmr_pkg::TICK_SLOW && !div_hit && !start0)
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_slow_tick: assert property (p_slow_tick)
    else $error("slow tick off divider");

  property p_reload_hold;
    ((sel_hi || sel_lo) && run_q[0] && !start0 && !restart0 && !tick_w)
      |=> cnt_q == $past(cnt_q);
  endproperty
  a_reload_hold: assert property (p_reload_hold)
    else $error("reload write disturbed counter");

endmodule

//--- shared/tmr_pkg.sv
// constants and carriers for the timer run-control and timer zero block
// assumes a 13.56 MHz system clock (the carrier) and a 32-bit AXI4-Lite register port
package tmr_pkg;

  // ==================================================================
  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_RUN_CTRL  = 6'h0E;
  localparam logic [5:0] IDX_T0_CTRL   = 6'h0F;
  localparam logic [5:0] IDX_T0_RLD_HI = 6'h10;
  localparam logic [5:0] IDX_T0_RLD_LO = 6'h11;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h18;
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h19;
  localparam logic [5:0] IDX_T0_COUNT  = 6'h1A;

  // ==================================================================
  // field positions
  localparam int RUN_ACT_LSB  = 4;
  localparam int RUN_MASK_LSB = 0;
  localparam int IRQ_UFLOW    = 0;
  localparam int IRQ_RXHALT   = 1;

  // ==================================================================
  // encodings
  localparam logic [1:0] START_NONE    = 2'h0;
  localparam logic [1:0] START_TX_END  = 2'h1;
  localparam logic [1:0] START_LFO_NUF = 2'h2;
  localparam logic [1:0] START_LFO_UF  = 2'h3;
  localparam logic [1:0] TICK_SYS      = 2'h0;
  localparam logic [1:0] TICK_SLOW     = 2'h1;
  localparam logic [1:0] TICK_T2_UF    = 2'h2;
  localparam logic [1:0] TICK_T1_UF    = 2'h3;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ==================================================================
  // reset values
  localparam logic [3:0] RUN_RST   = 4'h0;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [1:0] IRQ_RST   = 2'h0;

  // ==================================================================
  // tick rates: the slow tick is the carrier rate over the slow rate
  localparam int CARRIER_HZ = 13560000;
  localparam int SLOW_HZ    = 211875;
  localparam int SLOW_DIV   = CARRIER_HZ / SLOW_HZ;
  localparam logic [5:0] SLOW_DIV_MAX = 6'(SLOW_DIV - 1);

  // timer zero control layout, msb first
  typedef struct packed {
    logic       halt_on_rx;
    logic       rsvd6;
    logic [1:0] start_mode;
    logic       reload_on_zero;
    logic       rsvd2;
    logic [1:0] tick_select;
  } tmr_t0ctl_s;

endpackage

//--- sim/testbench.sv
// self-checking bench for the timer run control and timer zero block
// assumes the design answers on its axi4-lite port within a few cycles
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ==================================================================
  // signals
  localparam logic [5:0] RUN = tmr_pkg::IDX_RUN_CTRL;
  localparam logic [5:0] CTL = tmr_pkg::IDX_T0_CTRL;
  localparam logic [5:0] HI  = tmr_pkg::IDX_T0_RLD_HI;
  localparam logic [5:0] LO  = tmr_pkg::IDX_T0_RLD_LO;
  localparam logic [5:0] STA = tmr_pkg::IDX_IRQ_STAT;
  localparam logic [5:0] MSK = tmr_pkg::IDX_IRQ_MASK;
  localparam logic [5:0] CNT = tmr_pkg::IDX_T0_COUNT;
  localparam int TX = 0;
  localparam int RX = 1;
  localparam int OSC = 2;
  localparam int T1 = 3;
  localparam int T2 = 4;
  logic        clk_i, srst_i;
  logic [7:0]  aw_a, ar_a;
  logic        aw_v, w_v, b_r, ar_v, r_r, aw_r, w_r, b_v, ar_r, r_v;
  logic [31:0] w_d, r_d, rdat;
  logic [1:0]  b_p, r_p, resp;
  logic [4:0]  ev;
  logic [3:0]  act;
  logic        uf, irq;
  int          mismatches, comparisons, ufs;

  tmr_top tmr_top_inst (
    .clk_i(clk_i), .srst_i(srst_i),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_p), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_p),
    .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .tx_end_i(ev[TX]), .rx_first_nibble_i(ev[RX]),
    .low_freq_oscillator_i(ev[OSC]), .timer_one_uflow_i(ev[T1]),
    .timer_two_uflow_i(ev[T2]), .timer_active_o(act),
    .timer_zero_uflow_o(uf), .irq_o(irq));

  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  // the underflow pulse lasts one cycle, so count it mid-cycle
  always @(negedge clk_i) begin
    if (uf === 1'h1) ufs++;
  end
  // ==================================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic t;
    logic done;
    done = 1'h0;
    @(posedge clk_i);
    aw_a <= {idx, 2'h0};
    w_d <= {24'h0, d};
    aw_v <= 1'h1;
    w_v <= 1'h1;
    b_r <= 1'h1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk_i);
      t = aw_r & w_r;
      done = b_v;
      resp = b_p;
      @(posedge clk_i);
      if (t) begin
        aw_v <= 1'h0;
        w_v <= 1'h0;
      end
    end
    b_r <= 1'h0;
    if (!done) begin
      mismatches++;
      wrap_up();
    end
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [5:0] idx);
    logic t;
    logic done;
    done = 1'h0;
    @(posedge clk_i);
    ar_a <= {idx, 2'h0};
    ar_v <= 1'h1;
    r_r <= 1'h1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk_i);
      t = ar_r;
      done = r_v;
      rdat = r_d;
      resp = r_p;
      @(posedge clk_i);
      if (t) ar_v <= 1'h0;
    end
    r_r <= 1'h0;
    if (!done) begin
      mismatches++;
      wrap_up();
    end
    @(negedge clk_i);
  endtask
  task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(rdat, exp);
  endtask
  // pulses are spaced by an idle cycle so each one is a fresh edge
  task automatic pulse(input int b, input int k);
    repeat (k) begin
      @(posedge clk_i);
      ev[b] <= 1'h1;
      @(posedge clk_i);
      ev[b] <= 1'h0;
    end
    repeat (2) @(negedge clk_i);
  endtask
  // ==================================================================
  // sequence
  initial begin
    {aw_a, ar_a, aw_v, w_v, b_r, ar_v, r_r, w_d, ev} = '0;
    srst_i = 1'h1;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'h0;
    rchk(RUN, 32'h0);
    wr(CTL, 8'hFF);
    rchk(CTL, 32'hBB);
    wr(HI, 8'h12);
    wr(LO, 8'h34);
    rchk(LO, 32'h34);
    wr(CTL, 8'h02);
    wr(RUN, 8'hF0);
    chk(act, 32'h0);
    wr(RUN, 8'hFF);
    chk(act, 32'hF);
    rchk(RUN, 32'hF0);
    rchk(CNT, 32'h1234);
    wr(RUN, 8'h0E);
    rchk(RUN, 32'h10);
    pulse(T2, 3);
    rchk(CNT, 32'h1231);
    pulse(T1, 2);
    wr(HI, 8'h00);
    rchk(CNT, 32'h1231);
    wr(RUN, 8'h01);
    chk(act, 32'h0);
    wr(RUN, 8'h11);
    rchk(CNT, 32'h34);
    wr(RUN, 8'h01);
    wr(LO, 8'h02);
    wr(CTL, 8'h0A);
    wr(MSK, 8'h01);
    wr(RUN, 8'h11);
    pulse(T2, 3);
    chk(ufs, 32'h1);
    chk(act, 32'h1);
    rchk(CNT, 32'h2);
    rchk(STA, 32'h1);
    chk(irq, 32'h1);
    wr(STA, 8'h01);
    repeat (2) @(negedge clk_i);
    chk(irq, 32'h0);
    wr(CTL, 8'h02);
    pulse(T2, 3);
    chk(act, 32'h0);
    chk(ufs, 32'h2);
    wr(CTL, 8'h12);
    pulse(TX, 1);
    chk(act, 32'h1);
    pulse(RX, 1);
    chk(act, 32'h1);
    wr(CTL, 8'h92);
    pulse(RX, 1);
    chk(act, 32'h0);
    rchk(STA, 32'h3);
    wr(CTL, 8'h02);
    pulse(TX, 1);
    chk(act, 32'h0);
    wr(CTL, 8'hB2);
    pulse(OSC, 1);
    chk(act, 32'h1);
    pulse(RX, 1);
    chk(act, 32'h1);
    pulse(OSC, 1);
    chk(act, 32'h0);
    wr(CTL, 8'hA2);
    pulse(OSC, 1);
    pulse(T2, 3);
    chk(act, 32'h0);
    chk(ufs, 32'h2);
    wr(LO, 8'h10);
    wr(CTL, 8'h00);
    wr(RUN, 8'h11);
    repeat (30) @(negedge clk_i);
    chk(ufs, 32'h3);
    wr(LO, 8'h01);
    wr(CTL, 8'h01);
    wr(RUN, 8'h11);
    repeat (10) @(negedge clk_i);
    chk(act, 32'h1);
    repeat (200) @(negedge clk_i);
    chk(act, 32'h0);
    chk(ufs, 32'h4);
    wr(LO, 8'h03);
    wr(CTL, 8'h03);
    wr(RUN, 8'h11);
    pulse(T2, 2);
    pulse(T1, 2);
    rchk(CNT, 32'h1);
    chk(resp, tmr_pkg::RESP_OKAY);
    rd(6'h20);
    chk(resp, tmr_pkg::RESP_SLVERR);
    chk(rdat, 32'h0);
    wr(6'h20, 8'hFF);
    chk(resp, tmr_pkg::RESP_SLVERR);
    wrap_up();
  end
endmodule
